// >>> logic/etc_capture.sv
// Event timetag capture with single-channel single-edge results
//
// Summary of operation
// - Each input transition of the chosen polarity is one event.
// - Event counter counts every event, even during recovery.
// - Arming selects every Nth event or first event after time T.
// - A selected event stores event count and capture time as one record.
// - After a capture, recovery time blocks capture; armed events only counted.
// - Single-edge group uses channel A or B and one capture path.
// - Each record holds exactly one edge time and one event count.
// - Below the rate limit every chosen-polarity event can be captured.
// - Average frequency is count difference over time difference.
// - Average period is time difference over count difference.
// - Continuous interval is later minus earlier capture time.
// - Deviation is capture time minus time predicted from reference period.
// - Each closing record opens the next measurement: no dead time.
// - Records stream to memory readable while capture continues.
// - Optional divide-by-sixteen prescaler per channel, software selected.
`include "etc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module etc_capture
    import etc_pkg::*;
#(
    parameter int CNT_W = 48
)
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_chan_a,
    input wire logic i_chan_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic i_hready,
    input wire logic [31:0] i_hwdata,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic o_rec_valid,
    input wire logic i_rec_ready,
    output logic [2*CNT_W-1:0] o_rec_data,
    output logic o_result_valid,
    output logic [CNT_W-1:0] o_result
);
    localparam int REC_W = 2 * CNT_W;
    localparam logic [1:0] REC_CYC = 2'(`ETC_RECOVERY_CYC);
    localparam int PRE_W = $clog2(`ETC_PRESCALE_DIV);
    localparam int DIV_CW = $clog2(CNT_W + 1);

    function automatic logic [63:0] ext64(input logic [CNT_W-1:0] v);
        ext64 = 64'(v);
    endfunction : ext64

    logic [31:0] ctrl_q;
    logic [31:0] arm_n_q;
    logic [31:0] arm_t_q;
    logic [31:0] ref_q;
    logic [31:0] missed_q;
    logic wr_q;
    logic [7:0] wr_addr_q;
    logic [1:0] chan_in;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] sync3_q;
    logic [1:0] wave;
    logic sel_wave;
    logic sel_prev_q;
    logic event_p;
    logic run_q;
    logic [CNT_W-1:0] evcnt_q;
    logic [CNT_W-1:0] tbase_q;
    logic [31:0] arm_cnt_q;
    logic [31:0] tmr_q;
    logic tarmed_q;
    logic armed;
    logic [1:0] rec_cnt_q;
    logic fifo_ready;
    logic capture;
    logic have_first_q;
    logic [CNT_W-1:0] first_cnt_q;
    logic [CNT_W-1:0] first_time_q;
    logic [CNT_W-1:0] pred_q;
    logic [CNT_W-1:0] pred_next;
    logic [CNT_W-1:0] cap_cnt;
    logic [CNT_W-1:0] dev_q;
    logic pair_q;
    logic [CNT_W-1:0] de_q;
    logic [CNT_W-1:0] dt_q;
    etc_func_t func;
    etc_div_state_t div_st_q;
    logic [CNT_W:0] rem_q;
    logic [CNT_W-1:0] quo_q;
    logic [CNT_W-1:0] den_q;
    logic [DIV_CW-1:0] div_n_q;
    logic [CNT_W:0] rem_sh;
    logic quo_bit;
    logic [63:0] evc64;
    logic [63:0] res64;
    logic [REC_W-1:0] mem_q [2];
    logic wp_q;
    logic rp_q;
    logic [1:0] fcnt_q;
    logic push;
    logic pop;

    // Bus slave: never stalls, always OKAY
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign func = etc_func_t'(ctrl_q[`ETC_B_FUNC +: 2]);
    assign evc64 = ext64(evcnt_q);
    assign res64 = ext64(o_result);

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else if (i_hready)
        begin
            wr_q <= i_hsel & i_htrans[1] & i_hwrite;
            wr_addr_q <= i_haddr[7:0];
        end
    end

    // Read data is latched in the address phase, so a read right after a
    // write to the same register returns the old value.
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_hrdata <= 32'h0000_0000;
        else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite)
        begin
            unique case (i_haddr[7:0])
                `ETC_OFF_CTRL: o_hrdata <= ctrl_q;
                `ETC_OFF_ARM_N: o_hrdata <= arm_n_q;
                `ETC_OFF_ARM_T: o_hrdata <= arm_t_q;
                `ETC_OFF_REF: o_hrdata <= ref_q;
                `ETC_OFF_STATUS: o_hrdata <= {28'h0, fcnt_q, have_first_q,
                    div_st_q[1]};
                `ETC_OFF_EVC_LO: o_hrdata <= evc64[31:0];
                `ETC_OFF_EVC_HI: o_hrdata <= evc64[63:32];
                `ETC_OFF_RES_LO: o_hrdata <= res64[31:0];
                `ETC_OFF_RES_HI: o_hrdata <= res64[63:32];
                `ETC_OFF_MISSED: o_hrdata <= missed_q;
                default: o_hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ctrl_q <= `ETC_CTRL_RST;
            arm_n_q <= `ETC_ARM_N_RST;
            arm_t_q <= `ETC_ARM_T_RST;
            ref_q <= `ETC_REF_RST;
        end
        else if (wr_q)
        begin
            unique case (wr_addr_q)
                `ETC_OFF_CTRL: ctrl_q <= i_hwdata & 32'h0000_00ff;
                `ETC_OFF_ARM_N: arm_n_q <= i_hwdata;
                `ETC_OFF_ARM_T: arm_t_q <= i_hwdata;
                `ETC_OFF_REF: ref_q <= i_hwdata;
                default: ;
            endcase
        end
    end

    // Pins: two flops, then a third stage for the prescaler's rising-edge detect
    assign chan_in = {i_chan_b, i_chan_a};
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sync1_q <= 2'b00;
            sync2_q <= 2'b00;
            sync3_q <= 2'b00;
        end
        else
        begin
            sync1_q <= chan_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_pre
            logic [PRE_W-1:0] div_q;
            always_ff @(posedge i_clock or negedge i_reset_n)
            begin
                if (!i_reset_n)
                    div_q <= '0;
                else if (sync2_q[g] && !sync3_q[g])
                    div_q <= div_q + 1'b1;
            end
            // Top bit toggles once per 8 rising input edges, one full period per 16
            assign wave[g] = ctrl_q[`ETC_B_PRE_A + g] ? div_q[PRE_W-1] : sync2_q[g];
        end
    endgenerate

    assign sel_wave = ctrl_q[`ETC_B_CHAN_B] ? wave[1] : wave[0];
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            sel_prev_q <= 1'b0;
        else
            sel_prev_q <= sel_wave;
    end
    assign event_p = run_q & (ctrl_q[`ETC_B_FALL] ? (sel_prev_q & ~sel_wave)
                                                  : (~sel_prev_q & sel_wave));

    // Counter and time base restart when the run bit sets, and hold while it is clear
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            run_q <= 1'b0;
            evcnt_q <= '0;
            tbase_q <= '0;
        end
        else
        begin
            run_q <= ctrl_q[`ETC_B_RUN];
            if (ctrl_q[`ETC_B_RUN] && !run_q)
            begin
                evcnt_q <= '0;
                tbase_q <= '0;
            end
            else if (run_q)
            begin
                tbase_q <= tbase_q + 1'b1;
                if (event_p)
                    evcnt_q <= evcnt_q + 1'b1;
            end
        end
    end
    assign cap_cnt = evcnt_q + 1'b1;

    // Arming: Nth event, or first event once T cycles have passed
    assign armed = event_p & (ctrl_q[`ETC_B_ARM_T] ? tarmed_q
                                                   : (arm_cnt_q + 1 >= arm_n_q));
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            arm_cnt_q <= 32'h0;
            tmr_q <= 32'h0;
            tarmed_q <= 1'b0;
        end
        else if (!run_q)
        begin
            arm_cnt_q <= 32'h0;
            tmr_q <= 32'h0;
            tarmed_q <= 1'b0;
        end
        else
        begin
            if (armed)
                arm_cnt_q <= 32'h0;
            else if (event_p)
                arm_cnt_q <= arm_cnt_q + 1'b1;
            if (armed)
            begin
                tmr_q <= 32'h0;
                tarmed_q <= 1'b0;
            end
            else
            begin
                if (tmr_q + 1 >= arm_t_q)
                    tarmed_q <= 1'b1;
                tmr_q <= tmr_q + 1'b1;
            end
        end
    end

    // Armed events during recovery or with the buffer full are only counted
    assign capture = armed & (rec_cnt_q == 2'd0) & fifo_ready;
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rec_cnt_q <= 2'd0;
            missed_q <= 32'h0;
        end
        else
        begin
            // The capture cycle itself is the first cycle of recovery
            if (capture)
                rec_cnt_q <= REC_CYC - 2'd1;
            else if (rec_cnt_q != 2'd0)
                rec_cnt_q <= rec_cnt_q - 1'b1;
            if (armed && !capture)
                missed_q <= missed_q + 1'b1;
        end
    end

    // Predicted edge time advances by the reference period on every event after the first capture
    assign pred_next = pred_q + CNT_W'(ref_q);
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            have_first_q <= 1'b0;
            first_cnt_q <= '0;
            first_time_q <= '0;
            pred_q <= '0;
            dev_q <= '0;
            pair_q <= 1'b0;
            de_q <= '0;
            dt_q <= '0;
        end
        else
        begin
            pair_q <= 1'b0;
            if (!run_q)
                have_first_q <= 1'b0;
            else if (capture && !have_first_q)
            begin
                have_first_q <= 1'b1;
                pred_q <= tbase_q;
                first_cnt_q <= cap_cnt;
                first_time_q <= tbase_q;
            end
            else if (have_first_q)
            begin
                if (event_p)
                    pred_q <= pred_next;
                if (capture)
                begin
                    dev_q <= tbase_q - pred_next;
                    de_q <= cap_cnt - first_cnt_q;
                    dt_q <= tbase_q - first_time_q;
                    first_cnt_q <= cap_cnt;
                    first_time_q <= tbase_q;
                    pair_q <= 1'b1;
                end
            end
        end
    end

    // Serial divider; pairs arriving while busy update only the raw results
    assign rem_sh = {rem_q[CNT_W-1:0], quo_q[CNT_W-1]};
    assign quo_bit = (rem_sh >= {1'b0, den_q});
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            div_st_q <= ETC_DIV_IDLE;
            rem_q <= '0;
            quo_q <= '0;
            den_q <= '0;
            div_n_q <= '0;
            o_result <= '0;
            o_result_valid <= 1'b0;
        end
        else
        begin
            o_result_valid <= 1'b0;
            unique case (div_st_q)
                ETC_DIV_IDLE:
                begin
                    if (pair_q)
                    begin
                        unique case (func)
                            ETC_FUNC_INTERVAL:
                            begin
                                o_result <= dt_q;
                                o_result_valid <= 1'b1;
                            end
                            ETC_FUNC_DEVIATION:
                            begin
                                o_result <= dev_q;
                                o_result_valid <= 1'b1;
                            end
                            ETC_FUNC_FREQ:
                            begin
                                quo_q <= de_q << `ETC_FRAC_BITS;
                                den_q <= dt_q;
                                rem_q <= '0;
                                div_n_q <= DIV_CW'(CNT_W);
                                div_st_q <= ETC_DIV_RUN;
                            end
                            ETC_FUNC_PERIOD:
                            begin
                                quo_q <= dt_q;
                                den_q <= de_q;
                                rem_q <= '0;
                                div_n_q <= DIV_CW'(CNT_W);
                                div_st_q <= ETC_DIV_RUN;
                            end
                        endcase
                    end
                end
                ETC_DIV_RUN:
                begin
                    if (quo_bit)
                        rem_q <= rem_sh - {1'b0, den_q};
                    else
                        rem_q <= rem_sh;
                    quo_q <= {quo_q[CNT_W-2:0], quo_bit};
                    div_n_q <= div_n_q - 1'b1;
                    // Last step publishes the finished quotient directly
                    if (div_n_q == DIV_CW'(1))
                    begin
                        div_st_q <= ETC_DIV_IDLE;
                        o_result <= {quo_q[CNT_W-2:0], quo_bit};
                        o_result_valid <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Two-entry record buffer towards measurement memory
    assign fifo_ready = (fcnt_q != 2'd2);
    assign push = capture;
    assign pop = o_rec_valid & i_rec_ready;
    assign o_rec_valid = (fcnt_q != 2'd0);
    assign o_rec_data = mem_q[rp_q];
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            fcnt_q <= 2'd0;
        end
        else
        begin
            if (push)
            begin
                mem_q[wp_q] <= {cap_cnt, tbase_q};
                wp_q <= ~wp_q;
            end
            if (pop)
                rp_q <= ~rp_q;
            if (push && !pop)
                fcnt_q <= fcnt_q + 1'b1;
            else if (pop && !push)
                fcnt_q <= fcnt_q - 1'b1;
        end
    end
endmodule : etc_capture
`default_nettype wire

// >>> logic/etc_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ETC_MAP_SVH
`define ETC_MAP_SVH
`define ETC_OFF_CTRL 8'h00
`define ETC_OFF_ARM_N 8'h04
`define ETC_OFF_ARM_T 8'h08
`define ETC_OFF_REF 8'h0c
`define ETC_OFF_STATUS 8'h10
`define ETC_OFF_EVC_LO 8'h14
`define ETC_OFF_EVC_HI 8'h18
`define ETC_OFF_RES_LO 8'h1c
`define ETC_OFF_RES_HI 8'h20
`define ETC_OFF_MISSED 8'h24
`define ETC_B_RUN 0
`define ETC_B_CHAN_B 1
`define ETC_B_FALL 2
`define ETC_B_PRE_A 3
`define ETC_B_PRE_B 4
`define ETC_B_ARM_T 5
`define ETC_B_FUNC 6
`define ETC_CTRL_RST 32'h0000_0000
`define ETC_ARM_N_RST 32'h0000_0001
`define ETC_ARM_T_RST 32'h0000_0001
`define ETC_REF_RST 32'h0000_0001
`define ETC_CLK_NS 40
`define ETC_RECOVERY_NS 50
`define ETC_RECOVERY_CYC ((`ETC_RECOVERY_NS + `ETC_CLK_NS - 1) / `ETC_CLK_NS)
`define ETC_PRESCALE_DIV 16
`define ETC_FRAC_BITS 16
`endif

// >>> logic/etc_pkg.sv
// Types shared by the event timetag capture block
package etc_pkg;
    typedef enum logic [1:0]
    {
        ETC_FUNC_FREQ = 2'h0,
        ETC_FUNC_PERIOD = 2'h1,
        ETC_FUNC_INTERVAL = 2'h2,
        ETC_FUNC_DEVIATION = 2'h3
    } etc_func_t;
    typedef enum logic [1:0]
    {
        ETC_DIV_IDLE = 2'b01,
        ETC_DIV_RUN = 2'b10
    } etc_div_state_t;
endpackage : etc_pkg

// >>> sim/etc_capture_sva.sv
// Port-level assertions for the event timetag capture block
`timescale 1ns/100ps
`default_nettype none
module etc_capture_sva
#(
    parameter int CNT_W = 48
)
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_chan_a,
    input wire logic i_chan_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic o_rec_valid,
    input wire logic i_rec_ready,
    input wire logic [2*CNT_W-1:0] o_rec_data,
    input wire logic o_result_valid,
    input wire logic [CNT_W-1:0] o_result
);
    logic [7:0] since_edge_q;
    logic [1:0] pins_q;
    // Saturating age of the last pin change bounds how late a capture may follow it
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pins_q <= 2'h0;
            since_edge_q <= 8'hff;
        end
        else
        begin
            pins_q <= {i_chan_b, i_chan_a};
            if (pins_q != {i_chan_b, i_chan_a})
            begin
                since_edge_q <= 8'h00;
            end
            else if (since_edge_q != 8'hff)
            begin
                since_edge_q <= since_edge_q + 8'h01;
            end
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    chk_ready_high: assert property (o_hreadyout)
        else $error("hreadyout dropped");
    chk_resp_okay: assert property (!o_hresp)
        else $error("hresp not okay");
    chk_rec_hold: assert property (o_rec_valid && !i_rec_ready |=> o_rec_valid && $stable(o_rec_data))
        else $error("record lost while stalled");
    chk_rec_cause: assert property ($rose(o_rec_valid) |-> since_edge_q <= 8'h06)
        else $error("record without recent pin edge");
    chk_result_pulse: assert property (o_result_valid |=> !o_result_valid)
        else $error("result valid longer than one cycle");
    chk_result_hold: assert property ($changed(o_result) |-> o_result_valid)
        else $error("result changed without valid");
    chk_result_cause: assert property ($rose(o_result_valid) |-> since_edge_q <= 8'h50)
        else $error("result without recent capture");
    chk_unmapped_read: assert property (i_hsel && i_htrans[1] && i_hready && !i_hwrite
        && i_haddr[31:8] == 24'h0 && i_haddr[7:0] > 8'h24 |=> o_hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : etc_capture_sva
bind etc_capture etc_capture_sva #(.CNT_W(CNT_W)) u_sva
(
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_chan_a(i_chan_a),
    .i_chan_b(i_chan_b),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hready(i_hready),
    .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_rec_valid(o_rec_valid),
    .i_rec_ready(i_rec_ready),
    .o_rec_data(o_rec_data),
    .o_result_valid(o_result_valid),
    .o_result(o_result)
);
`default_nettype wire

// >>> sim/etc_comparator_model.sv
// Comparator output model: square wave on one channel for a set number of toggles
`timescale 1ns/100ps
`default_nettype none
module etc_comparator_model
(
    input wire logic i_clock,
    input wire logic i_start,
    input wire logic i_sel_b,
    input wire logic [7:0] i_half,
    input wire logic [7:0] i_toggles,
    output logic o_chan_a,
    output logic o_chan_b,
    output logic o_busy
);
    int left;
    int cnt;
    initial
    begin
        o_chan_a = 1'b0;
        o_chan_b = 1'b0;
        o_busy = 1'b0;
    end
    // Falling-edge changes keep pin edges away from the sampling edge
    always @(negedge i_clock)
    begin
        if (!o_busy && i_start === 1'b1)
        begin
            left = i_toggles;
            cnt = i_half;
            o_busy = 1'b1;
        end
        else if (o_busy)
        begin
            cnt--;
            if (cnt == 0)
            begin
                if (i_sel_b) o_chan_b = !o_chan_b;
                else o_chan_a = !o_chan_a;
                cnt = i_half;
                left--;
                o_busy = (left != 0);
            end
        end
    end
endmodule : etc_comparator_model
`default_nettype wire

// >>> sim/etc_capture_tb_top.sv
// Self-checking testbench for the event timetag capture block
`include "etc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module etc_capture_tb_top
    import etc_pkg::*;
;
    logic clk, rst_n, hsel, hwrite, hready, hresp, rdy, rec_v, res_v;
    logic chan_a, chan_b, go, sel_b, busy;
    logic [31:0] haddr, hwdata, hrdata, junk, m0;
    logic [1:0] htrans;
    logic [95:0] rec_d;
    logic [47:0] res;
    logic [7:0] half, tog;
    logic [95:0] rec_q[$];
    logic [47:0] res_q[$];
    int failures, checked, cycles;
    etc_capture #(.CNT_W(48)) u_dut
    (
        .i_clock(clk),
        .i_reset_n(rst_n),
        .i_chan_a(chan_a),
        .i_chan_b(chan_b),
        .i_hsel(hsel),
        .i_haddr(haddr),
        .i_htrans(htrans),
        .i_hwrite(hwrite),
        .i_hsize(3'h2),
        .i_hready(hready),
        .i_hwdata(hwdata),
        .o_hrdata(hrdata),
        .o_hreadyout(hready),
        .o_hresp(hresp),
        .o_rec_valid(rec_v),
        .i_rec_ready(rdy),
        .o_rec_data(rec_d),
        .o_result_valid(res_v),
        .o_result(res)
    );
    etc_comparator_model u_comp
    (
        .i_clock(clk),
        .i_start(go),
        .i_sel_b(sel_b),
        .i_half(half),
        .i_toggles(tog),
        .o_chan_a(chan_a),
        .o_chan_b(chan_b),
        .o_busy(busy)
    );
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Stands in for the record memory and the result reader
    always @(posedge clk)
    begin
        cycles++;
        if (rec_v === 1'b1 && rdy === 1'b1) rec_q.push_back(rec_d);
        if (res_v === 1'b1) res_q.push_back(res);
        if (cycles == 40000)
        begin
            failures++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Address phase held until hready, then data phase held until hready again
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(what, {16'h0, exp}, {16'h0, r});
    endtask : rdchk
    task automatic setup(input logic [31:0] n, input logic [31:0] rp, input logic [31:0] c);
        bus(1'b1, `ETC_OFF_CTRL, 32'h0, junk);
        bus(1'b1, `ETC_OFF_ARM_N, n, junk);
        bus(1'b1, `ETC_OFF_REF, rp, junk);
        rec_q.delete();
        res_q.delete();
        bus(1'b1, `ETC_OFF_CTRL, c, junk);
    endtask : setup
    task automatic feed(input logic b, input logic [7:0] h, input logic [7:0] t);
        @(posedge clk);
        sel_b <= b;
        half <= h;
        tog <= t;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        while (busy === 1'b1) @(posedge clk);
        repeat (80) @(posedge clk);
    endtask : feed
    task automatic recs(input int n, input logic [47:0] de, input logic [47:0] dt);
        chk("record count", n, rec_q.size());
        for (int i = 1; i < rec_q.size(); i++)
        begin
            chk("count step", de, rec_q[i][95:48] - rec_q[i-1][95:48]);
            chk("time step", dt, rec_q[i][47:0] - rec_q[i-1][47:0]);
        end
    endtask : recs
    task automatic t_regs();
        rdchk("ctrl reset", `ETC_OFF_CTRL, `ETC_CTRL_RST);
        rdchk("arm_n reset", `ETC_OFF_ARM_N, `ETC_ARM_N_RST);
        rdchk("ref reset", `ETC_OFF_REF, `ETC_REF_RST);
        bus(1'b1, 8'h40, 32'hffff_ffff, junk);
        rdchk("unmapped", 8'h40, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_interval();
        setup(1, 1, {24'h0, ETC_FUNC_INTERVAL, 6'h01});
        feed(1'b0, 8'd5, 8'd16);
        recs(8, 1, 10);
        chk("result count", 7, res_q.size());
        foreach (res_q[i]) chk("interval", 10, res_q[i]);
        rdchk("event count", `ETC_OFF_EVC_LO, 8);
        $display("test interval done");
    endtask : t_interval
    task automatic t_nth_fall_b();
        setup(3, 1, {24'h0, ETC_FUNC_INTERVAL, 6'h07});
        feed(1'b1, 8'd4, 8'd24);
        recs(4, 3, 24);
        rdchk("event count", `ETC_OFF_EVC_LO, 12);
        $display("test every nth falling b done");
    endtask : t_nth_fall_b
    task automatic t_stall();
        rdy <= 1'b0;
        setup(1, 1, {24'h0, ETC_FUNC_INTERVAL, 6'h01});
        bus(1'b0, `ETC_OFF_MISSED, 32'h0, m0);
        feed(1'b0, 8'd3, 8'd8);
        bus(1'b0, `ETC_OFF_STATUS, 32'h0, junk);
        chk("buffer level", 2, junk[3:2]);
        bus(1'b0, `ETC_OFF_MISSED, 32'h0, junk);
        chk("missed", 2, junk - m0);
        rdchk("event count", `ETC_OFF_EVC_LO, 4);
        rdy <= 1'b1;
        repeat (6) @(posedge clk);
        recs(2, 1, 6);
        $display("test stall done");
    endtask : t_stall
    task automatic t_prescale();
        setup(1, 1, {24'h0, ETC_FUNC_INTERVAL, 6'h09});
        feed(1'b0, 8'd2, 8'd64);
        recs(2, 1, 64);
        rdchk("event count", `ETC_OFF_EVC_LO, 2);
        $display("test prescale done");
    endtask : t_prescale
    task automatic t_funcs();
        // Frequency is scaled by 2^16 per clock tick and truncated
        logic [47:0] exp_tab[4] = '{48'd1092, 48'd60, 48'd60, 48'd0};
        for (int f = 0; f < 4; f++)
        begin
            setup(1, 60, {24'h0, etc_func_t'(f), 6'h01});
            feed(1'b0, 8'd30, 8'd6);
            chk("result count", 2, res_q.size());
            foreach (res_q[i]) chk("result", exp_tab[f], res_q[i]);
        end
        $display("test functions done");
    endtask : t_funcs
    initial
    begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        rdy = 1'b1;
        go = 1'b0;
        sel_b = 1'b0;
        half = 8'h1;
        tog = 8'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_interval();
        t_nth_fall_b();
        t_stall();
        t_prescale();
        t_funcs();
        complete_run();
    end
endmodule : etc_capture_tb_top
`default_nettype wire
